/* pkg/drsp_pkg.sv */
// shared constants and types of the dual-bank register page target
// assumes one device clock, one free-running link sampling clock
package drsp_pkg;
    localparam int NBANK = 2;
    localparam int NCH = 4;
    localparam int REGS_PER_CH = 4;
    localparam int NSHARE = 4;
    localparam int NSTRAP = 2;
    localparam int THERM_W = 3;
    localparam int STRAP_MODE = 0;
    localparam int STRAP_ADDR = 1;
    localparam int IDX_W = 2;
    localparam int SH_HI_BIT = 4;
    localparam int SH_LO_BIT = 0;
    // target address ranges and level codes
    localparam logic [6:0] BASE_LOW = 7'h18;
    localparam logic [6:0] BASE_HIGH = 7'h20;
    localparam logic [6:0] PAIR_ODD = 7'h01;
    localparam logic [1:0] LVL_ONE = 2'h1;
    localparam logic [1:0] LVL_TWO = 2'h2;
    // register page layout
    localparam logic [7:0] OFF_GRP_MASK = 8'hFC;
    localparam logic [7:0] OFF_SH_MASK = 8'hFE;
    localparam logic [7:0] OFF_CH0 = 8'h00;
    localparam logic [7:0] OFF_CH1 = 8'h20;
    localparam logic [7:0] OFF_BC_A = 8'h80;
    localparam logic [7:0] OFF_BC_B = 8'hA0;
    localparam logic [7:0] OFF_SH_A = 8'hE2;
    localparam logic [7:0] OFF_SH_B = 8'hF0;
    localparam logic [7:0] PTR_STEP = 8'h01;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BIT_STEP = 4'h1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_AACK = 3'b010,
        ST_RX = 3'b011,
        ST_WACK = 3'b100,
        ST_TX = 3'b101,
        ST_RACK = 3'b110
    } drsp_state_e;

    typedef logic [NSTRAP-1:0][THERM_W-1:0] drsp_straps_t;
    typedef logic [NSTRAP-1:0][1:0] drsp_levels_t;
    typedef logic [NCH-1:0][REGS_PER_CH-1:0][7:0] drsp_chan_t;
    typedef logic [NBANK-1:0][NSHARE-1:0][7:0] drsp_share_t;

    typedef struct packed {
        logic [6:0] bank0;
        logic [6:0] bank1;
        logic valid;
    } drsp_pair_s;

    typedef struct packed {
        logic ch;
        logic sel;
        logic bc;
        logic shr;
        logic [IDX_W-1:0] idx;
        logic [1:0] sidx;
    } drsp_dec_s;
endpackage

/* hdl/drsp_bank_target.sv */
// two-address bus target with one register page per channel bank
// assumes srst_in is the internal power-on reset on mclk_in, and that
// link_clk_in runs free and oversamples scl/sda several times per bit
`timescale 1ns/10ps

module drsp_bank_target
    import drsp_pkg::*;
(
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic link_clk_in,
    input wire drsp_straps_t strap_therm_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    output drsp_levels_t strap_level_out,
    output drsp_pair_s addr_pair_out,
    output drsp_chan_t chan_cfg_out,
    output drsp_share_t share_cfg_out
);

    typedef struct packed {
        drsp_straps_t t1;
        drsp_straps_t t2;
        logic latched;
        drsp_levels_t lvl;
        drsp_pair_s pair;
    } drsp_mst_s;

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_p;
        logic sda_s1;
        logic sda_s2;
        logic sda_p;
        logic rst_s1;
        logic rst_s2;
        logic ok_s1;
        logic ok_s2;
        drsp_state_e st;
        logic [3:0] bitcnt;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic bank;
        logic rw;
        logic nak;
        logic have_ptr;
        logic oe;
        logic wr_evt;
        logic rd_evt;
        logic [7:0] ev_off;
        drsp_chan_t chan;
        drsp_share_t share;
    } drsp_lnk_s;

    drsp_mst_s m_q, m_d;
    drsp_lnk_s q, d;
    drsp_levels_t lvl_c;
    drsp_dec_s dec_ev;
    logic rise, fall, start, stop;

    // page decode of one offset
    function automatic drsp_dec_s dec(input logic [7:0] off);
        drsp_dec_s r;
        r = '0;
        r.ch = ((off & OFF_GRP_MASK) == OFF_CH0) || ((off & OFF_GRP_MASK) == OFF_CH1);
        r.sel = ((off & OFF_GRP_MASK) == OFF_CH1);
        r.bc = ((off & OFF_GRP_MASK) == OFF_BC_A) || ((off & OFF_GRP_MASK) == OFF_BC_B);
        r.shr = ((off & OFF_SH_MASK) == OFF_SH_A) || ((off & OFF_SH_MASK) == OFF_SH_B);
        r.idx = off[IDX_W-1:0];
        r.sidx = {off[SH_HI_BIT], off[SH_LO_BIT]};
        return r;
    endfunction

    // read data of one offset; shared range has no gating
    function automatic logic [7:0] rd(input drsp_lnk_s s, input logic [7:0] off);
        drsp_dec_s r;
        r = dec(off);
        if (r.ch) begin
            rd = s.chan[{s.bank, r.sel}][r.idx];
        end else if (r.bc) begin
            rd = s.chan[{s.bank, 1'b0}][r.idx];
        end else if (r.shr) begin
            rd = s.share[s.bank][r.sidx];
        end else begin
            rd = '0;
        end
    endfunction

    // four-level resolution: count of set comparator outputs
    for (genvar i = 0; i < NSTRAP; i++) begin : g_lvl
        assign lvl_c[i] = 2'(m_q.t2[i][0]) + 2'(m_q.t2[i][1]) + 2'(m_q.t2[i][2]);
    end

    // device clock: strap capture after reset release
    always_comb begin
        m_d = m_q;
        m_d.t1 = strap_therm_in;
        m_d.t2 = m_q.t1;
        if (srst_in) begin
            m_d.latched = 1'b0;
            m_d.lvl = '0;
            m_d.pair = '0;
        end else if (!m_q.latched) begin
            m_d.latched = 1'b1;
            m_d.lvl = lvl_c;
            m_d.pair.valid = (lvl_c[STRAP_MODE] == LVL_ONE) || (lvl_c[STRAP_MODE] == LVL_TWO);
            m_d.pair.bank0 = ((lvl_c[STRAP_MODE] == LVL_ONE) ? BASE_LOW : BASE_HIGH)
                | {4'h0, lvl_c[STRAP_ADDR], 1'b0};
            m_d.pair.bank1 = m_d.pair.bank0 | PAIR_ODD;
        end
    end

    always_ff @(posedge mclk_in) begin
        m_q <= m_d;
    end

    // link bus conditions from synchronised samples
    assign rise = q.scl_s2 && !q.scl_p;
    assign fall = !q.scl_s2 && q.scl_p;
    assign start = q.scl_s2 && q.scl_p && q.sda_p && !q.sda_s2;
    assign stop = q.scl_s2 && q.scl_p && !q.sda_p && q.sda_s2;
    assign dec_ev = dec(q.ev_off);

    // link clock: bus target and register page
    always_comb begin
        drsp_dec_s w;
        w = dec(q.ptr);
        d = q;
        d.scl_s1 = scl_in;
        d.scl_s2 = q.scl_s1;
        d.scl_p = q.scl_s2;
        d.sda_s1 = sda_in;
        d.sda_s2 = q.sda_s1;
        d.sda_p = q.sda_s2;
        d.rst_s1 = srst_in;
        d.rst_s2 = q.rst_s1;
        d.ok_s1 = m_q.latched; // pair is static once this flag is seen
        d.ok_s2 = q.ok_s1;
        d.wr_evt = 1'b0;
        d.rd_evt = 1'b0;
        if (start) begin
            d.st = ST_ADDR;
            d.bitcnt = '0;
            d.oe = 1'b0;
        end else if (stop) begin
            d.st = ST_IDLE;
            d.oe = 1'b0;
        end else begin
            unique case (q.st)
                ST_IDLE: begin
                    d.oe = 1'b0;
                end
                ST_ADDR, ST_RX: begin
                    if (rise) begin
                        d.sh = {q.sh[6:0], q.sda_s2};
                        d.bitcnt = q.bitcnt + BIT_STEP;
                    end else if (fall && q.bitcnt == BITS_PER_BYTE) begin
                        d.bitcnt = '0;
                        d.oe = 1'b1;
                        if (q.st == ST_RX) begin
                            d.st = ST_WACK;
                            d.ptr = q.have_ptr ? q.ptr + PTR_STEP : q.sh;
                            d.have_ptr = 1'b1;
                            if (q.have_ptr) begin
                                d.wr_evt = 1'b1;
                                d.ev_off = q.ptr;
                                if (w.ch) begin
                                    d.chan[{q.bank, w.sel}][w.idx] = q.sh;
                                end else if (w.bc) begin
                                    for (int c = 0; c < NCH / NBANK; c++) begin
                                        d.chan[{q.bank, c[0]}][w.idx] = q.sh;
                                    end
                                end else if (w.shr) begin
                                    d.share[q.bank][w.sidx] = q.sh;
                                end
                            end
                        end else if (q.ok_s2 && m_q.pair.valid
                            && (q.sh[7:1] == m_q.pair.bank0 || q.sh[7:1] == m_q.pair.bank1)) begin
                            d.st = ST_AACK;
                            d.bank = (q.sh[7:1] == m_q.pair.bank1);
                            d.rw = q.sh[0];
                            d.have_ptr = 1'b0;
                        end else begin
                            d.st = ST_IDLE;
                            d.oe = 1'b0;
                        end
                    end
                end
                ST_AACK, ST_WACK, ST_RACK: begin
                    if (rise && q.st == ST_RACK) begin
                        d.nak = q.sda_s2;
                    end else if (fall) begin
                        if (q.st == ST_RACK && q.nak) begin
                            d.st = ST_IDLE;
                            d.oe = 1'b0;
                        end else if (q.st == ST_RACK || (q.st == ST_AACK && q.rw)) begin
                            d.sh = rd(q, q.ptr);
                            d.oe = !d.sh[7];
                            d.ptr = q.ptr + PTR_STEP;
                            d.rd_evt = 1'b1;
                            d.ev_off = q.ptr;
                            d.st = ST_TX;
                        end else begin
                            d.oe = 1'b0;
                            d.st = ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (rise) begin
                        d.bitcnt = q.bitcnt + BIT_STEP;
                    end else if (fall && q.bitcnt == BITS_PER_BYTE) begin
                        d.bitcnt = '0;
                        d.oe = 1'b0;
                        d.st = ST_RACK;
                    end else if (fall) begin
                        d.sh = {q.sh[6:0], 1'b0};
                        d.oe = !q.sh[6];
                    end
                end
                default: begin
                    d.st = ST_IDLE;
                    d.oe = 1'b0;
                end
            endcase
        end
        if (q.rst_s2) begin
            d.st = ST_IDLE;
            d.bitcnt = '0;
            d.sh = '0;
            d.ptr = '0;
            d.bank = 1'b0;
            d.rw = 1'b0;
            d.nak = 1'b0;
            d.have_ptr = 1'b0;
            d.oe = 1'b0;
            d.wr_evt = 1'b0;
            d.rd_evt = 1'b0;
            d.ev_off = '0;
            d.chan = '0;
            d.share = '0;
        end
    end

    always_ff @(posedge link_clk_in) begin
        q <= d;
    end

    // open-drain data pin and configuration outputs
    assign sda_out = 1'b0;
    assign sda_oe_out = q.oe;
    assign strap_level_out = m_q.lvl;
    assign addr_pair_out = m_q.pair;
    assign chan_cfg_out = q.chan;
    assign share_cfg_out = q.share;

    // device clock checks
    chk_reset_clears: assert property (@(posedge mclk_in) srst_in |=> !m_q.latched)
        else $error("latch flag survived reset");
    chk_pair_held: assert property (@(posedge mclk_in) disable iff (srst_in)
        m_q.latched && $past(m_q.latched) |-> $stable(m_q.pair) && $stable(m_q.lvl))
        else $error("address pair changed after latch");
    chk_level_take: assert property (@(posedge mclk_in) disable iff (srst_in)
        $rose(m_q.latched) |-> m_q.lvl == $past(lvl_c))
        else $error("latched levels differ from resolved straps");
    chk_pair_map: assert property (@(posedge mclk_in) disable iff (srst_in)
        m_q.pair.valid |-> m_q.pair.bank1 == m_q.pair.bank0 + 7'h01 && !m_q.pair.bank0[0]
        && m_q.pair.bank0 >= BASE_LOW && m_q.pair.bank1 <= 7'h27)
        else $error("address pair outside map");

    // link clock checks
    sequence s_addr_taken;
        q.st == ST_AACK && $past(q.st) == ST_ADDR;
    endsequence
    chk_addr_match: assert property (@(posedge link_clk_in) disable iff (q.rst_s2)
        s_addr_taken |-> q.oe && q.sh[7:1] == (q.bank ? m_q.pair.bank1 : m_q.pair.bank0))
        else $error("acknowledged a foreign address");
    chk_bcast_write: assert property (@(posedge link_clk_in) disable iff (q.rst_s2)
        q.wr_evt && dec_ev.bc |-> q.chan[{q.bank, 1'b0}][dec_ev.idx] == q.sh
        && q.chan[{q.bank, 1'b1}][dec_ev.idx] == q.sh)
        else $error("broadcast write missed a channel");
    chk_chan_iso: assert property (@(posedge link_clk_in) disable iff (q.rst_s2)
        q.wr_evt && dec_ev.ch |-> q.chan[{q.bank, dec_ev.sel}][dec_ev.idx] == q.sh
        && (dec_ev.sel ? $stable(q.chan[{q.bank, 1'b0}]) : $stable(q.chan[{q.bank, 1'b1}])))
        else $error("channel write leaked to its neighbour");
    chk_share_write: assert property (@(posedge link_clk_in) disable iff (q.rst_s2)
        q.wr_evt && dec_ev.shr |-> q.share[q.bank][dec_ev.sidx] == q.sh)
        else $error("shared register not written");
    chk_unmapped: assert property (@(posedge link_clk_in) disable iff (q.rst_s2)
        (q.wr_evt || q.rd_evt) && !(dec_ev.ch || dec_ev.bc || dec_ev.shr)
        |-> $stable(q.chan) && $stable(q.share) && (q.wr_evt || q.sh == 8'h00))
        else $error("unmapped offset had an effect");
    chk_bcast_read: assert property (@(posedge link_clk_in) disable iff (q.rst_s2)
        q.rd_evt && dec_ev.bc |-> q.sh == q.chan[{q.bank, 1'b0}][dec_ev.idx])
        else $error("broadcast read not from first channel");
endmodule

/* bench/drsp_host_model.sv */
// bus host model: bit-banged master that drives scl and pulls sda low
// assumes the bench resolves the open-drain sda with a pull-up
`timescale 1ns/10ps
module drsp_host_model (
    input wire logic mclk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    int q = 8; // quarter bit in mclk cycles, raise it for a slow host
    // scl stands high and sda is released outside frames
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // one quarter bit, every change lands on a falling mclk edge
    task automatic wq();
        repeat (q) @(negedge mclk_in);
    endtask
    // start or repeated start
    task automatic start();
        sda_low_out = 1'b0;
        wq();
        scl_out = 1'b1;
        wq();
        sda_low_out = 1'b1;
        wq();
        scl_out = 1'b0;
    endtask
    // stop, then the bus is left idle
    task automatic stop();
        wq();
        sda_low_out = 1'b1;
        wq();
        scl_out = 1'b1;
        wq();
        sda_low_out = 1'b0;
        wq();
    endtask
    // one bit: data set mid-low, sampled mid-high
    task automatic bit_io(input logic v, output logic r);
        wq();
        sda_low_out = ~v;
        wq();
        scl_out = 1'b1;
        wq();
        r = sda_in;
        wq();
        scl_out = 1'b0;
    endtask
    // whole-byte writes only, so no read-modify-write is needed
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    // read one byte msb first, then ack or nak it
    task automatic rbyte(input logic nak, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(nak, r);
    endtask
endmodule

/* bench/tb_top.sv */
// testbench of the dual-bank register page target
// assumes one device on the bus with the host model as its only master
`timescale 1ns/10ps
module tb_top;
    import drsp_pkg::*;
    logic mclk_in = 1'b0;
    logic link_clk_in = 1'b0;
    logic srst_in = 1'b1;
    drsp_straps_t strap_therm_in = '0;
    logic scl;
    logic sda_low;
    logic sda_line;
    logic sda_out;
    logic sda_oe_out;
    drsp_levels_t strap_level_out;
    drsp_pair_s addr_pair_out;
    drsp_chan_t chan_cfg_out;
    drsp_share_t share_cfg_out;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    // clocks: 20 ns device clock, 30 ns link clock whose rising edges never meet mclk's
    always #10 mclk_in = ~mclk_in;
    always #15 link_clk_in = ~link_clk_in;
    // open-drain sda with pull-up; the target's pin level counts while it is enabled
    assign sda_line = sda_oe_out ? (sda_out & ~sda_low) : ~sda_low;

    drsp_bank_target drsp_bank_target_inst (.mclk_in(mclk_in), .srst_in(srst_in),
        .link_clk_in(link_clk_in), .strap_therm_in(strap_therm_in), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
        .strap_level_out(strap_level_out), .addr_pair_out(addr_pair_out),
        .chan_cfg_out(chan_cfg_out), .share_cfg_out(share_cfg_out));
    drsp_host_model drsp_host_model_inst (.mclk_in(mclk_in), .sda_in(sda_line),
        .scl_out(scl), .sda_low_out(sda_low));

    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic cmp_pair(input drsp_pair_s got, input drsp_pair_s exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // hang guard, the whole run needs well under this
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_errors++;
            finish_test();
        end
    end
    function automatic logic [2:0] th(input int n);
        return 3'((1 << n) - 1);
    endfunction
    // straps set, reset held 5 cycles, link side given time to settle
    task automatic do_reset(input int m, input int a);
        strap_therm_in[0] = th(m);
        strap_therm_in[1] = th(a);
        srst_in = 1'b1;
        repeat (5) @(negedge mclk_in);
        srst_in = 1'b0;
        repeat (10) @(negedge mclk_in);
    endtask
    // bank 0 answers at 0x18, bank 1 at 0x19 after the last strap test
    task automatic wr(input logic b, input logic [7:0] off, input logic [7:0] d0,
            input logic [7:0] d1, input int n);
        logic ack;
        drsp_host_model_inst.start();
        drsp_host_model_inst.wbyte({7'h18 + 7'(b), 1'b0}, ack);
        cmp_byte(8'(ack), 8'h01);
        drsp_host_model_inst.wbyte(off, ack);
        cmp_byte(8'(ack), 8'h01);
        for (int i = 0; i < n; i++) begin
            drsp_host_model_inst.wbyte(i == 0 ? d0 : d1, ack);
            cmp_byte(8'(ack), 8'h01);
        end
        drsp_host_model_inst.stop();
    endtask
    task automatic rd(input logic b, input logic [7:0] off, output logic [7:0] v);
        logic ack;
        drsp_host_model_inst.start();
        drsp_host_model_inst.wbyte({7'h18 + 7'(b), 1'b0}, ack);
        drsp_host_model_inst.wbyte(off, ack);
        drsp_host_model_inst.start();
        drsp_host_model_inst.wbyte({7'h18 + 7'(b), 1'b1}, ack);
        cmp_byte(8'(ack), 8'h01);
        drsp_host_model_inst.rbyte(1'b1, v);
        drsp_host_model_inst.stop();
    endtask
    // every mode and address level, then straps moved after release
    task automatic test_straps();
        drsp_pair_s exp;
        for (int m = 0; m < 4; m++) begin
            for (int a = 0; a < 4; a++) begin
                do_reset(m, a);
                cmp_byte({4'h0, strap_level_out}, {4'h0, 2'(a), 2'(m)});
                exp.valid = (m == 1 || m == 2);
                exp.bank0 = (m == 2 ? 7'h20 : 7'h18) + 7'(2 * a);
                exp.bank1 = exp.bank0 + 7'h01;
                if (exp.valid) cmp_pair(addr_pair_out, exp);
                else cmp_byte(8'(addr_pair_out.valid), 8'h00);
            end
        end
        // straps moved after release leave the latched pair at 0x18 and 0x19
        do_reset(1, 0);
        strap_therm_in = {th(3), th(2)};
        repeat (20) @(negedge mclk_in);
        cmp_pair(addr_pair_out, '{bank0: 7'h18, bank1: 7'h19, valid: 1'b1});
        $display("test_straps done");
    endtask
    task automatic test_channel();
        logic [7:0] v;
        wr(1'b0, 8'h01, 8'h08, 8'h00, 1);
        wr(1'b0, 8'h21, 8'h5A, 8'h00, 1);
        wr(1'b1, 8'h01, 8'h11, 8'h00, 1);
        wr(1'b1, 8'h23, 8'h3C, 8'h00, 1);
        cmp_byte(chan_cfg_out[0][1], 8'h08);
        cmp_byte(chan_cfg_out[1][1], 8'h5A);
        cmp_byte(chan_cfg_out[2][1], 8'h11);
        cmp_byte(chan_cfg_out[3][1], 8'h00);
        cmp_byte(chan_cfg_out[3][3], 8'h3C);
        rd(1'b0, 8'h21, v);
        cmp_byte(v, 8'h5A);
        $display("test_channel done");
    endtask
    // broadcast writes, reads after the channels are made to differ
    task automatic test_broadcast();
        logic [7:0] v;
        wr(1'b0, 8'h83, 8'hC3, 8'h00, 1);
        cmp_byte(chan_cfg_out[0][3], 8'hC3);
        cmp_byte(chan_cfg_out[1][3], 8'hC3);
        wr(1'b0, 8'h23, 8'h77, 8'h00, 1);
        cmp_byte(chan_cfg_out[0][3], 8'hC3);
        rd(1'b0, 8'h83, v);
        cmp_byte(v, 8'hC3);
        rd(1'b0, 8'hA3, v);
        cmp_byte(v, 8'hC3);
        wr(1'b1, 8'hA0, 8'h96, 8'h00, 1);
        cmp_byte(chan_cfg_out[2][0], 8'h96);
        cmp_byte(chan_cfg_out[3][0], 8'h96);
        wr(1'b1, 8'h20, 8'h55, 8'h00, 1);
        rd(1'b1, 8'hA0, v);
        cmp_byte(v, 8'h96);
        rd(1'b1, 8'h80, v);
        cmp_byte(v, 8'h96);
        $display("test_broadcast done");
    endtask
    // two-byte bursts into both shared ranges of bank 1
    task automatic test_shared();
        logic [7:0] v;
        logic [7:0] e[4] = '{8'hA1, 8'hA2, 8'hB1, 8'hB2};
        wr(1'b1, 8'hE2, 8'hA1, 8'hA2, 2);
        wr(1'b1, 8'hF0, 8'hB1, 8'hB2, 2);
        for (int i = 0; i < 4; i++) cmp_byte(share_cfg_out[1][i], e[i]);
        cmp_byte(share_cfg_out[0][0], 8'h00);
        rd(1'b1, 8'hF1, v);
        cmp_byte(v, 8'hB2);
        $display("test_shared done");
    endtask
    // unmapped offsets and a foreign address
    task automatic test_unmapped();
        logic [7:0] v;
        logic ack;
        wr(1'b0, 8'h04, 8'hFF, 8'h00, 1);
        wr(1'b1, 8'hE4, 8'hFF, 8'h00, 1);
        cmp_byte(chan_cfg_out[0][0], 8'h00);
        cmp_byte(share_cfg_out[1][1], 8'hA2);
        rd(1'b0, 8'h04, v);
        cmp_byte(v, 8'h00);
        rd(1'b1, 8'hE4, v);
        cmp_byte(v, 8'h00);
        drsp_host_model_inst.start();
        drsp_host_model_inst.wbyte({7'h1A, 1'b0}, ack);
        cmp_byte(8'(ack), 8'h00);
        drsp_host_model_inst.stop();
        $display("test_unmapped done");
    endtask
    // main sequence
    initial begin
        test_straps();
        test_channel();
        test_broadcast();
        test_shared();
        test_unmapped();
        finish_test();
    end
endmodule
